// ===== stf_pkg.sv
package stf_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int STF_DATA_W = 16;
    localparam int STF_SEL_W = 4;

    // ****************************************
    // Filter register indices
    // ****************************************
    localparam logic [STF_SEL_W-1:0] STF_IDX_OPER_RISE = 4'h0;
    localparam logic [STF_SEL_W-1:0] STF_IDX_OPER_FALL = 4'h1;
    localparam logic [STF_SEL_W-1:0] STF_IDX_TRIG_RISE = 4'h2;
    localparam logic [STF_SEL_W-1:0] STF_IDX_TRIG_FALL = 4'h3;
    localparam logic [STF_SEL_W-1:0] STF_IDX_ARM_RISE = 4'h4;
    localparam logic [STF_SEL_W-1:0] STF_IDX_ARM_FALL = 4'h5;
    localparam logic [STF_SEL_W-1:0] STF_IDX_SEQ_RISE = 4'h6;
    localparam logic [STF_SEL_W-1:0] STF_IDX_SEQ_FALL = 4'h7;

    // ****************************************
    // Bit positions
    // ****************************************
    localparam int STF_OPER_SETTLE_BIT = 1;
    localparam int STF_OPER_TRIG_BIT = 5;
    localparam int STF_OPER_ARM_BIT = 6;
    localparam int STF_OPER_IDLE_BIT = 10;
    localparam int STF_SEQ_ONE_BIT = 1;
    localparam int STF_LAYER_ONE_BIT = 1;
    localparam int STF_LAYER_TWO_BIT = 2;

    // ****************************************
    // Implemented bits and reset values
    // ****************************************
    localparam logic [STF_DATA_W-1:0] STF_OPER_MASK = 16'h0462;
    localparam logic [STF_DATA_W-1:0] STF_TRIG_MASK = 16'h0002;
    localparam logic [STF_DATA_W-1:0] STF_ARM_MASK = 16'h0002;
    localparam logic [STF_DATA_W-1:0] STF_SEQ_MASK = 16'h0006;
    localparam logic [STF_DATA_W-1:0] STF_OPER_RISE_RST = 16'h0462;
    localparam logic [STF_DATA_W-1:0] STF_TRIG_RISE_RST = 16'h0002;
    localparam logic [STF_DATA_W-1:0] STF_ARM_RISE_RST = 16'h0002;
    localparam logic [STF_DATA_W-1:0] STF_SEQ_RISE_RST = 16'h0006;
    localparam logic [STF_DATA_W-1:0] STF_FALL_RST = 16'h0000;

endpackage : stf_pkg

// ===== stf_edge_cell.sv
`timescale 1ns/100ps
module stf_edge_cell
    import stf_pkg::*;
#(
    parameter int WIDTH = STF_DATA_W,
    parameter logic [WIDTH-1:0] IMPL_MASK = '1,
    parameter logic [WIDTH-1:0] RISE_RST = '0,
    parameter logic [WIDTH-1:0] FALL_RST = '0
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // Condition bits
    input wire logic [WIDTH-1:0] cond_i,
    // Filter programming
    input wire logic wr_rise_i,
    input wire logic wr_fall_i,
    input wire logic [WIDTH-1:0] wdata_i,
    // Filter contents and event set pulses
    output logic [WIDTH-1:0] rise_o,
    output logic [WIDTH-1:0] fall_o,
    output logic [WIDTH-1:0] event_set_o
);

    if (WIDTH < 1 || WIDTH > STF_DATA_W) begin : g_bad_width
        $error("stf_edge_cell: WIDTH out of range");
    end

    logic [WIDTH-1:0] rise_r;
    logic [WIDTH-1:0] fall_r;
    logic [WIDTH-1:0] prev_r;
    logic [WIDTH-1:0] event_r;
    logic prime_r;

    // ****************************************
    // Edge detection
    // ****************************************
    wire [WIDTH-1:0] rise_edge = cond_i & ~prev_r;
    wire [WIDTH-1:0] fall_edge = ~cond_i & prev_r;
    // First sample after reset only primes; no edge is invented from reset state
    wire [WIDTH-1:0] event_nxt = prime_r ? ((rise_edge & rise_r) | (fall_edge & fall_r)) : '0;
    // Unused bits never store, so they read back zero
    wire [WIDTH-1:0] rise_nxt = wr_rise_i ? (wdata_i & IMPL_MASK) : rise_r;
    wire [WIDTH-1:0] fall_nxt = wr_fall_i ? (wdata_i & IMPL_MASK) : fall_r;

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            rise_r <= RISE_RST & IMPL_MASK;
            fall_r <= FALL_RST & IMPL_MASK;
            prev_r <= '0;
            event_r <= '0;
            prime_r <= 1'b0;
        end else if (ce_i) begin
            rise_r <= rise_nxt;
            fall_r <= fall_nxt;
            prev_r <= cond_i;
            event_r <= event_nxt;
            prime_r <= 1'b1;
        end
    end

    assign rise_o = rise_r;
    assign fall_o = fall_r;
    assign event_set_o = event_r;

endmodule : stf_edge_cell

// ===== stf_filter_bank.sv
`timescale 1ns/100ps
module stf_filter_bank
    import stf_pkg::*;
(
    // Clock, reset, enable
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // Sequencer conditions
    input wire logic relay_settling_i,
    input wire logic trigger_layer_wait_i,
    input wire logic arm_layer_wait_i,
    input wire logic idle_state_i,
    input wire logic arm_layer_one_flag_i,
    input wire logic arm_layer_two_flag_i,
    // Filter command port
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [STF_SEL_W-1:0] sel_i,
    input wire logic [STF_DATA_W-1:0] wdata_i,
    output logic [STF_DATA_W-1:0] rdata_o,
    output logic rvalid_o,
    output logic sel_err_o,
    // Event register set pulses
    output logic [STF_DATA_W-1:0] oper_event_set_o,
    output logic [STF_DATA_W-1:0] trig_event_set_o,
    output logic [STF_DATA_W-1:0] arm_event_set_o,
    output logic [STF_DATA_W-1:0] seq_event_set_o
);

    // ****************************************
    // Condition vectors
    // ****************************************
    logic [STF_DATA_W-1:0] oper_cond;
    logic [STF_DATA_W-1:0] trig_cond;
    logic [STF_DATA_W-1:0] arm_cond;
    logic [STF_DATA_W-1:0] seq_cond;
    wire sequence_one_flag = arm_layer_wait_i;

    always_comb begin
        oper_cond = '0;
        oper_cond[STF_OPER_SETTLE_BIT] = relay_settling_i;
        oper_cond[STF_OPER_TRIG_BIT] = trigger_layer_wait_i;
        oper_cond[STF_OPER_ARM_BIT] = arm_layer_wait_i;
        oper_cond[STF_OPER_IDLE_BIT] = idle_state_i;
        trig_cond = '0;
        trig_cond[STF_SEQ_ONE_BIT] = trigger_layer_wait_i;
        arm_cond = '0;
        arm_cond[STF_SEQ_ONE_BIT] = sequence_one_flag;
        seq_cond = '0;
        seq_cond[STF_LAYER_ONE_BIT] = arm_layer_one_flag_i;
        seq_cond[STF_LAYER_TWO_BIT] = arm_layer_two_flag_i;
    end

    // ****************************************
    // Write decode
    // ****************************************
    wire wr_oper_rise = wr_i && (sel_i == STF_IDX_OPER_RISE);
    wire wr_oper_fall = wr_i && (sel_i == STF_IDX_OPER_FALL);
    wire wr_trig_rise = wr_i && (sel_i == STF_IDX_TRIG_RISE);
    wire wr_trig_fall = wr_i && (sel_i == STF_IDX_TRIG_FALL);
    wire wr_arm_rise = wr_i && (sel_i == STF_IDX_ARM_RISE);
    wire wr_arm_fall = wr_i && (sel_i == STF_IDX_ARM_FALL);
    wire wr_seq_rise = wr_i && (sel_i == STF_IDX_SEQ_RISE);
    wire wr_seq_fall = wr_i && (sel_i == STF_IDX_SEQ_FALL);

    logic [STF_DATA_W-1:0] oper_rise;
    logic [STF_DATA_W-1:0] oper_fall;
    logic [STF_DATA_W-1:0] trig_rise;
    logic [STF_DATA_W-1:0] trig_fall;
    logic [STF_DATA_W-1:0] arm_rise;
    logic [STF_DATA_W-1:0] arm_fall;
    logic [STF_DATA_W-1:0] seq_rise;
    logic [STF_DATA_W-1:0] seq_fall;

    // ****************************************
    // Filter groups
    // ****************************************
    stf_edge_cell #(
        .WIDTH(STF_DATA_W),
        .IMPL_MASK(STF_OPER_MASK),
        .RISE_RST(STF_OPER_RISE_RST),
        .FALL_RST(STF_FALL_RST)
    ) u_oper (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .cond_i(oper_cond),
        .wr_rise_i(wr_oper_rise),
        .wr_fall_i(wr_oper_fall),
        .wdata_i(wdata_i),
        .rise_o(oper_rise),
        .fall_o(oper_fall),
        .event_set_o(oper_event_set_o)
    );

    stf_edge_cell #(
        .WIDTH(STF_DATA_W),
        .IMPL_MASK(STF_TRIG_MASK),
        .RISE_RST(STF_TRIG_RISE_RST),
        .FALL_RST(STF_FALL_RST)
    ) u_trig (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .cond_i(trig_cond),
        .wr_rise_i(wr_trig_rise),
        .wr_fall_i(wr_trig_fall),
        .wdata_i(wdata_i),
        .rise_o(trig_rise),
        .fall_o(trig_fall),
        .event_set_o(trig_event_set_o)
    );

    stf_edge_cell #(
        .WIDTH(STF_DATA_W),
        .IMPL_MASK(STF_ARM_MASK),
        .RISE_RST(STF_ARM_RISE_RST),
        .FALL_RST(STF_FALL_RST)
    ) u_arm (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .cond_i(arm_cond),
        .wr_rise_i(wr_arm_rise),
        .wr_fall_i(wr_arm_fall),
        .wdata_i(wdata_i),
        .rise_o(arm_rise),
        .fall_o(arm_fall),
        .event_set_o(arm_event_set_o)
    );

    stf_edge_cell #(
        .WIDTH(STF_DATA_W),
        .IMPL_MASK(STF_SEQ_MASK),
        .RISE_RST(STF_SEQ_RISE_RST),
        .FALL_RST(STF_FALL_RST)
    ) u_seq (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .cond_i(seq_cond),
        .wr_rise_i(wr_seq_rise),
        .wr_fall_i(wr_seq_fall),
        .wdata_i(wdata_i),
        .rise_o(seq_rise),
        .fall_o(seq_fall),
        .event_set_o(seq_event_set_o)
    );

    // ****************************************
    // Readback
    // ****************************************
    // Binary contents are returned as is; the command layer prints them in decimal
    logic [STF_DATA_W-1:0] rd_sel_data;
    logic rd_sel_hit;

    always_comb begin
        rd_sel_hit = 1'b1;
        case (sel_i)
            STF_IDX_OPER_RISE: rd_sel_data = oper_rise;
            STF_IDX_OPER_FALL: rd_sel_data = oper_fall;
            STF_IDX_TRIG_RISE: rd_sel_data = trig_rise;
            STF_IDX_TRIG_FALL: rd_sel_data = trig_fall;
            STF_IDX_ARM_RISE: rd_sel_data = arm_rise;
            STF_IDX_ARM_FALL: rd_sel_data = arm_fall;
            STF_IDX_SEQ_RISE: rd_sel_data = seq_rise;
            STF_IDX_SEQ_FALL: rd_sel_data = seq_fall;
            default: begin
                rd_sel_data = '0;
                rd_sel_hit = 1'b0;
            end
        endcase
    end

    logic [STF_DATA_W-1:0] rdata_r;
    logic rvalid_r;
    logic sel_err_r;
    wire [STF_DATA_W-1:0] rdata_nxt = rd_i ? rd_sel_data : rdata_r;
    wire sel_err_nxt = (rd_i || wr_i) && !rd_sel_hit;

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_r <= '0;
            rvalid_r <= 1'b0;
            sel_err_r <= 1'b0;
        end else if (ce_i) begin
            rdata_r <= rdata_nxt;
            rvalid_r <= rd_i;
            sel_err_r <= sel_err_nxt;
        end
    end

    assign rdata_o = rdata_r;
    assign rvalid_o = rvalid_r;
    assign sel_err_o = sel_err_r;

    // ****************************************
    // Checks
    // ****************************************
    // Mirrors the priming of the cells so checks skip the first sample
    logic watch_r;
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            watch_r <= 1'b0;
        end else if (ce_i) begin
            watch_r <= 1'b1;
        end
    end

    // Checker helper only; it follows the enable itself, so the enable must not freeze it
    logic ce_seen_r;
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            ce_seen_r <= 1'b0;
        end else begin
            ce_seen_r <= ce_i;
        end
    end

    wire live = ce_i && ce_seen_r && watch_r;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    oper_settle_rise_a: assert property (
        live && $rose(relay_settling_i) && oper_rise[STF_OPER_SETTLE_BIT]
        |=> oper_event_set_o[STF_OPER_SETTLE_BIT])
        else $error("settling start did not set operation B1");

    oper_trig_rise_a: assert property (
        live && $rose(trigger_layer_wait_i) && oper_rise[STF_OPER_TRIG_BIT]
        |=> oper_event_set_o[STF_OPER_TRIG_BIT])
        else $error("trigger wait did not set operation B5");

    oper_arm_rise_a: assert property (
        live && $rose(arm_layer_wait_i) && oper_rise[STF_OPER_ARM_BIT]
        |=> oper_event_set_o[STF_OPER_ARM_BIT])
        else $error("arm wait did not set operation B6");

    oper_idle_rise_a: assert property (
        live && $rose(idle_state_i) && oper_rise[STF_OPER_IDLE_BIT]
        |=> oper_event_set_o[STF_OPER_IDLE_BIT])
        else $error("idle entry did not set operation B10");

    oper_rise_gate_a: assert property (
        live && $rose(arm_layer_wait_i) && !oper_rise[STF_OPER_ARM_BIT]
        |=> !oper_event_set_o[STF_OPER_ARM_BIT])
        else $error("disabled rise filter still set operation B6");

    oper_fall_gate_a: assert property (
        live && $fell(idle_state_i) && !oper_fall[STF_OPER_IDLE_BIT]
        |=> !oper_event_set_o[STF_OPER_IDLE_BIT])
        else $error("disabled fall filter still set operation B10");

    oper_rise_map_a: assert property (
        (oper_rise & ~STF_OPER_MASK) == '0)
        else $error("operation rise filter holds an unused bit");

    oper_fall_map_a: assert property (
        (oper_fall & ~STF_OPER_MASK) == '0)
        else $error("operation fall filter holds an unused bit");

    trig_seq_rise_a: assert property (
        live && $rose(trigger_layer_wait_i) && trig_rise[STF_SEQ_ONE_BIT]
        |=> trig_event_set_o[STF_SEQ_ONE_BIT])
        else $error("trigger wait did not set trigger B1");

    arm_seq_rise_a: assert property (
        (live && $rose(arm_layer_wait_i) && arm_rise[STF_SEQ_ONE_BIT]
        |=> arm_event_set_o[STF_SEQ_ONE_BIT]) and ((arm_rise | arm_fall) & ~STF_ARM_MASK) == '0)
        else $error("arm filter misbehaved");

    seq_layer_one_a: assert property (
        live && $rose(arm_layer_one_flag_i) && seq_rise[STF_LAYER_ONE_BIT]
        |=> seq_event_set_o[STF_LAYER_ONE_BIT])
        else $error("arm layer one did not set sequence B1");

    seq_layer_two_a: assert property (
        live && $rose(arm_layer_two_flag_i) && seq_rise[STF_LAYER_TWO_BIT]
        |=> seq_event_set_o[STF_LAYER_TWO_BIT])
        else $error("arm layer two did not set sequence B2");

    read_value_a: assert property (
        ce_i && rd_i && !wr_i |=> rvalid_o && rdata_o == $past(rd_sel_data))
        else $error("readback value differs from filter contents");

    seq_event_cause_a: assert property (
        ce_i && $past(ce_i) && $past(ce_i, 2) && seq_event_set_o[STF_LAYER_TWO_BIT]
        && !$past(seq_event_set_o[STF_LAYER_TWO_BIT])
        |-> ($past(arm_layer_two_flag_i) != $past(arm_layer_two_flag_i, 2))
            && ($past(arm_layer_two_flag_i) ? $past(seq_rise[STF_LAYER_TWO_BIT])
                : $past(seq_fall[STF_LAYER_TWO_BIT])))
        else $error("sequence B2 set without an enabled change");

    trig_fall_a: assert property (
        live && $fell(trigger_layer_wait_i) && trig_fall[STF_SEQ_ONE_BIT]
        |=> trig_event_set_o[STF_SEQ_ONE_BIT])
        else $error("trigger exit did not set trigger B1");

    oper_settle_fall_a: assert property (
        live && $fell(relay_settling_i) && oper_fall[STF_OPER_SETTLE_BIT]
        |=> oper_event_set_o[STF_OPER_SETTLE_BIT])
        else $error("settling end did not set operation B1");

    oper_trig_fall_a: assert property (
        live && $fell(trigger_layer_wait_i) && oper_fall[STF_OPER_TRIG_BIT]
        |=> oper_event_set_o[STF_OPER_TRIG_BIT])
        else $error("trigger exit did not set operation B5");

    oper_arm_fall_a: assert property (
        live && $fell(arm_layer_wait_i) && oper_fall[STF_OPER_ARM_BIT]
        |=> oper_event_set_o[STF_OPER_ARM_BIT])
        else $error("arm exit did not set operation B6");

    oper_idle_fall_a: assert property (
        live && $fell(idle_state_i) && oper_fall[STF_OPER_IDLE_BIT]
        |=> oper_event_set_o[STF_OPER_IDLE_BIT])
        else $error("idle exit did not set operation B10");

    arm_seq_fall_a: assert property (
        live && $fell(arm_layer_wait_i) && arm_fall[STF_SEQ_ONE_BIT]
        |=> arm_event_set_o[STF_SEQ_ONE_BIT])
        else $error("arm exit did not set arm B1");

    seq_one_fall_a: assert property (
        live && $fell(arm_layer_one_flag_i) && seq_fall[STF_LAYER_ONE_BIT]
        |=> seq_event_set_o[STF_LAYER_ONE_BIT])
        else $error("arm layer one exit did not set sequence B1");

    seq_two_fall_a: assert property (
        live && $fell(arm_layer_two_flag_i) && seq_fall[STF_LAYER_TWO_BIT]
        |=> seq_event_set_o[STF_LAYER_TWO_BIT])
        else $error("arm layer two exit did not set sequence B2");

    bad_index_read_a: assert property (
        ce_i && rd_i && sel_i > STF_IDX_SEQ_FALL |=> sel_err_o && rdata_o == '0)
        else $error("bad index read was not refused");

    seq_write_drop_a: assert property (
        ce_i && wr_i && sel_i == STF_IDX_SEQ_RISE |=> seq_rise == (STF_SEQ_MASK & $past(wdata_i)))
        else $error("sequence rise filter kept an unused bit");

    prime_quiet_a: assert property (
        !watch_r |=> (oper_event_set_o | trig_event_set_o | arm_event_set_o | seq_event_set_o) == '0)
        else $error("event pulse on the priming edge");

    unused_read_zero_a: assert property (
        rvalid_o |-> (rdata_o & ~(STF_OPER_MASK | STF_SEQ_MASK)) == '0)
        else $error("readback shows an unused bit");

    settle_both_c: cover property (live && $rose(relay_settling_i) ##[1:20] $fell(relay_settling_i));
    seq_layer_c: cover property (seq_event_set_o[STF_LAYER_ONE_BIT] ##[1:20] seq_event_set_o[STF_LAYER_TWO_BIT]);
    write_read_c: cover property (wr_i && sel_i == STF_IDX_OPER_FALL ##1 rd_i && sel_i == STF_IDX_OPER_FALL);
    bad_sel_c: cover property (sel_err_o);

endmodule : stf_filter_bank

// ===== stf_host_model.sv
`timescale 1ns/100ps
module stf_host_model
    import stf_pkg::*;
(
    // Clock
    input wire logic clock_i,
    // Command port
    output logic wr_o,
    output logic rd_o,
    output logic [STF_SEL_W-1:0] sel_o,
    output logic [STF_DATA_W-1:0] wdata_o
);
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        sel_o = 4'h0;
        wdata_o = 16'h0000;
    end

    // ****************************************
    // Command tasks
    // ****************************************
    // One command per call; back to back calls keep the port busy
    task cmd(input logic w, input logic r, input logic [STF_SEL_W-1:0] s, input logic [STF_DATA_W-1:0] d);
        @(negedge clock_i);
        wr_o <= w;
        rd_o <= r;
        sel_o <= s;
        wdata_o <= d;
    endtask : cmd

    // Idle lines show the inverse so stale values are never taken as fresh
    task release_port();
        @(negedge clock_i);
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        sel_o <= ~sel_o;
        wdata_o <= ~wdata_o;
    endtask : release_port

    // The written value is the sum of the weights of the bits to set
    task write_sum(input logic [STF_SEL_W-1:0] s, input int w0, input int w1);
        cmd(1'b1, 1'b0, s, 16'(w0 + w1));
    endtask : write_sum
endmodule : stf_host_model

// ===== tb_status_transition_filters.sv
`timescale 1ns/100ps
module tb_status_transition_filters;
    import stf_pkg::*;
    localparam logic [15:0] MASKS [4] = '{STF_OPER_MASK, STF_TRIG_MASK, STF_ARM_MASK, STF_SEQ_MASK};
    localparam logic [15:0] RISE_RST [4] = '{STF_OPER_RISE_RST, STF_TRIG_RISE_RST, STF_ARM_RISE_RST,
        STF_SEQ_RISE_RST};
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic ce_i = 1'b1;
    // Settling, trigger wait, arm wait, idle, layer one, layer two
    logic [5:0] cond = 6'h00;
    logic [5:0] prev;
    logic wr, rd, rvalid, sel_err, m_rv, m_err, primed;
    logic [STF_SEL_W-1:0] sel;
    logic [STF_DATA_W-1:0] wdata, rdata, m_rd;
    logic [STF_DATA_W-1:0] ev [4];
    logic [STF_DATA_W-1:0] m_ev [4];
    logic [STF_DATA_W-1:0] filt [8];
    int errors = 0;
    int n_checks = 0;

    always #50 clock_i = ~clock_i;

    stf_host_model stf_host_model_i (.clock_i(clock_i), .wr_o(wr), .rd_o(rd), .sel_o(sel), .wdata_o(wdata));

    stf_filter_bank stf_filter_bank_i (
        .clock_i(clock_i), .reset_i(reset_i), .ce_i(ce_i),
        .relay_settling_i(cond[0]), .trigger_layer_wait_i(cond[1]), .arm_layer_wait_i(cond[2]),
        .idle_state_i(cond[3]), .arm_layer_one_flag_i(cond[4]), .arm_layer_two_flag_i(cond[5]),
        .wr_i(wr), .rd_i(rd), .sel_i(sel), .wdata_i(wdata), .rdata_o(rdata), .rvalid_o(rvalid),
        .sel_err_o(sel_err), .oper_event_set_o(ev[0]), .trig_event_set_o(ev[1]),
        .arm_event_set_o(ev[2]), .seq_event_set_o(ev[3])
    );

    // ****************************************
    // Reference model
    // ****************************************
    function automatic logic [15:0] grp(input int g, input logic [5:0] c);
        case (g)
            0: grp = (16'(c[0]) << 1) | (16'(c[1]) << 5) | (16'(c[2]) << 6) | (16'(c[3]) << 10);
            1: grp = 16'(c[1]) << 1;
            2: grp = 16'(c[2]) << 1;
            default: grp = (16'(c[4]) << 1) | (16'(c[5]) << 2);
        endcase
    endfunction : grp

    function automatic logic [15:0] evt(input int g, input logic [5:0] p, input logic [5:0] c);
        evt = (~grp(g, p) & grp(g, c) & filt[2*g]) | (grp(g, p) & ~grp(g, c) & filt[2*g+1]);
    endfunction : evt

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            for (int g = 0; g < 4; g++) begin
                filt[2*g] <= RISE_RST[g];
                filt[2*g+1] <= STF_FALL_RST;
                m_ev[g] <= 16'h0000;
            end
            m_rd <= 16'h0000;
            m_rv <= 1'b0;
            m_err <= 1'b0;
            primed <= 1'b0;
        end else if (ce_i) begin
            primed <= 1'b1;
            prev <= cond;
            for (int g = 0; g < 4; g++) begin
                m_ev[g] <= primed ? evt(g, prev, cond) : 16'h0000;
            end
            m_rv <= rd;
            m_err <= (rd | wr) & sel[3];
            if (rd) begin
                m_rd <= sel[3] ? 16'h0000 : filt[sel[2:0]];
            end
            if (wr & ~sel[3]) begin
                filt[sel[2:0]] <= wdata & MASKS[sel[2:1]];
            end
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    always @(negedge clock_i) begin
        if (!reset_i) begin
            chk(16'(rvalid), 16'(m_rv));
            chk(16'(sel_err), 16'(m_err));
            chk(rdata, m_rd);
            chk(ev[0], m_ev[0]);
            chk(ev[1], m_ev[1]);
            chk(ev[2], m_ev[2]);
            chk(ev[3], m_ev[3]);
        end
    end

    // ****************************************
    // Test sequence
    // ****************************************
    task end_of_test();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test

    task run_random(input int n);
        fork
            repeat (n) begin
                @(negedge clock_i);
                cond <= ($urandom % 2) ? 6'($urandom) : cond;
                ce_i <= ($urandom % 8) != 0;
            end
            repeat (n) begin
                if ($urandom % 3 == 0) begin
                    stf_host_model_i.release_port();
                end else begin
                    stf_host_model_i.cmd(1'($urandom), 1'($urandom), 4'($urandom), 16'($urandom));
                end
            end
        join
        stf_host_model_i.release_port();
        @(negedge clock_i);
        ce_i <= 1'b1;
    endtask : run_random

    task read_all();
        for (int i = 0; i < 16; i++) begin
            stf_host_model_i.cmd(1'b0, 1'b1, 4'(i), 16'h0000);
        end
        stf_host_model_i.release_port();
    endtask : read_all

    initial begin
        void'($urandom(32'h2a5f_809d));
        repeat (16) @(posedge clock_i);
        @(negedge clock_i);
        reset_i <= 1'b0;
        read_all();
        // Arm plus trigger on rise, settling plus idle on fall
        stf_host_model_i.write_sum(STF_IDX_OPER_RISE, 64, 32);
        stf_host_model_i.write_sum(STF_IDX_OPER_FALL, 1024, 2);
        stf_host_model_i.cmd(1'b0, 1'b1, STF_IDX_OPER_RISE, 16'h0000);
        stf_host_model_i.cmd(1'b0, 1'b1, STF_IDX_OPER_FALL, 16'h0000);
        chk(rdata, 16'h0060);
        stf_host_model_i.release_port();
        chk(rdata, 16'h0402);
        for (int b = 0; b < 24; b++) begin
            @(negedge clock_i);
            cond <= cond ^ (6'h01 << (b % 6));
        end
        // All ones: unused bits must drop, every condition caught both ways
        for (int i = 0; i < 8; i++) begin
            stf_host_model_i.cmd(1'b1, 1'b0, 4'(i), 16'hffff);
        end
        read_all();
        for (int b = 0; b < 24; b++) begin
            @(negedge clock_i);
            cond <= cond ^ (6'h01 << (b % 6));
        end
        run_random(2000);
        @(negedge clock_i);
        reset_i <= 1'b1;
        @(negedge clock_i);
        reset_i <= 1'b0;
        cond <= ~cond;
        read_all();
        run_random(1000);
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge clock_i);
        errors++;
        end_of_test();
    end
endmodule : tb_status_transition_filters
